// ---- hdl/fps_pkg.sv ----
/*
 * Constants, register map and reset values for the feedback position
 * scaling block. Assumes a single 125 MHz clock and a simple word-wide
 * parameter access port addressed by the parameter numbers below.
 */
// How it works
// RL1: Fieldbus position is cut from the 64-bit native word to 32 bits.
// RL2: Low 32 bits are angle within a turn, high 32 bits count turns.
// RL3: Scale field takes 0 to 32, resets to 20, gives 2^N counts per turn.
// RL4: Same scaling serves actual position and following error objects.
// RL5: Scaled value is the 64-bit word shifted right by 32 minus scale, low 32 kept.
// RL6: Feedback pole count is read-only to host, range 2 to 128, default 2.
// RL7: Pole count gives single poles; feeds commutation and velocity scaling.
// RL8: On enable, motor poles over feedback poles must be whole, else fault.
// RL9: Phase-find control takes 0 or 1, resets 0; 1 runs the angle search.
// RL10: Phase-find current lies from zero to drive peak current, resets 0.
// RL11: Resolver ratio 0.001 to 50.000, default 0.5, sets excitation amplitude.
// RL12: Resolver phase lag in electrical degrees, -180 to 180, default -2.
package fps_pkg;
    localparam logic [15:0] FPS_ADDR_PFIND_CTL  = 16'h012A;
    localparam logic [15:0] FPS_ADDR_PFIND_CUR  = 16'h012C;
    localparam logic [15:0] FPS_ADDR_POLES      = 16'h012E;
    localparam logic [15:0] FPS_ADDR_PSCALE     = 16'h0130;
    localparam logic [15:0] FPS_ADDR_RES_RATIO  = 16'h0132;
    localparam logic [15:0] FPS_ADDR_RES_LAG    = 16'h0134;

    // Scaled fixed point: ratio in thousandths, lag in whole degrees
    localparam logic [31:0] FPS_RST_PFIND_CTL   = 32'h0000_0000;
    localparam logic [31:0] FPS_RST_PFIND_CUR   = 32'h0000_0000;
    localparam logic [31:0] FPS_RST_POLES       = 32'h0000_0002;
    localparam logic [31:0] FPS_RST_PSCALE      = 32'h0000_0014;
    localparam logic [31:0] FPS_RST_RES_RATIO   = 32'h0000_01F4;
    localparam logic [31:0] FPS_RST_RES_LAG     = 32'hFFFF_FFFE;

    localparam logic [31:0] FPS_PSCALE_MAX      = 32'h0000_0020;
    localparam logic [31:0] FPS_POLES_MIN       = 32'h0000_0002;
    localparam logic [31:0] FPS_POLES_MAX       = 32'h0000_0080;
    localparam logic [31:0] FPS_RATIO_MIN       = 32'h0000_0001;
    localparam logic [31:0] FPS_RATIO_MAX       = 32'h0000_C350;
    localparam logic [31:0] FPS_LAG_MIN         = 32'hFFFF_FF4C;
    localparam logic [31:0] FPS_LAG_MAX         = 32'h0000_00B4;
    localparam int          FPS_POS_W           = 64;
    localparam int          FPS_HALF_W          = 32;

    typedef enum logic [1:0] {FPS_CHK_IDLE, FPS_CHK_RUN, FPS_CHK_DONE} fps_chk_t;
endpackage : fps_pkg

// ---- hdl/fps_scale_if.sv ----
/*
 * Interface carrying one 64-bit position into the scaler and its
 * 32-bit scaled answer back. Assumes the scale is already range-checked.
 */
`timescale 1ns/100ps
interface fps_scale_if;
    logic [63:0] pos_in;
    logic [5:0]  scale;
    logic [31:0] pos_out;
    modport user   (output pos_in, output scale, input pos_out);
    modport scaler (input pos_in, input scale, output pos_out);
endinterface : fps_scale_if

// ---- hdl/fps_scaler.sv ----
/*
 * Registered position scaler: one cycle from native word to fieldbus word.
 * Assumes scale never exceeds 32.
 */
`timescale 1ns/100ps
module fps_scaler
    import fps_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst_b,
    fps_scale_if.scaler sif
);
    wire logic [5:0]           shift_amt;
    wire logic [FPS_POS_W-1:0] shifted;

    // RL5: shift by 32 minus scale
    assign shift_amt = 6'(FPS_HALF_W) - sif.scale;
    assign shifted   = sif.pos_in >> shift_amt;

    // RL1: keep only the low word
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sif.pos_out <= 32'h0000_0000;
        end else begin
            sif.pos_out <= shifted[31:0];
        end
    end

    a_scale_result: assert property (@(posedge clock) disable iff (!rst_b) // RL5
        $past(rst_b) |-> sif.pos_out == $past(shifted[31:0]))
        else $error("scaled position does not follow shifted input");
    a_scale_turns: assert property (@(posedge clock) disable iff (!rst_b) // RL2
        sif.scale == 6'h00 |=> sif.pos_out == $past(sif.pos_in[63:32]))
        else $error("scale 0 does not give the turn count");
    a_scale_angle: assert property (@(posedge clock) disable iff (!rst_b) // RL2
        sif.scale == 6'h20 |=> sif.pos_out == $past(sif.pos_in[31:0]))
        else $error("scale 32 does not give the angle");
endmodule : fps_scaler

// ---- hdl/fps_top.sv ----
/*
 * Feedback setting block: parameter registers, fieldbus position scaling
 * for actual position and following error, and the pole ratio check.
 * Assumes a synchronous word-wide parameter port and a drive controller
 * that pulses enable_req when the drive moves to enabled.
 */
`timescale 1ns/100ps
module fps_top
    import fps_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        prm_wr,
    input  wire logic        prm_rd,
    input  wire logic [15:0] prm_addr,
    input  wire logic [31:0] prm_wdata,
    output logic      [31:0] prm_rdata,
    output logic             prm_err,
    input  wire logic [63:0] pos_actual,
    input  wire logic [63:0] pos_follow_err,
    output wire logic [31:0] fb_pos_actual,
    output wire logic [31:0] fb_follow_err,
    output wire logic [31:0] mech_angle,
    output wire logic [31:0] turn_count,
    input  wire logic        poles_load,
    input  wire logic [7:0]  poles_value,
    input  wire logic [7:0]  motor_poles,
    input  wire logic [31:0] drive_peak_current,
    input  wire logic        enable_req,
    output logic             enable_ok,
    output logic             pole_fault,
    output wire logic        phase_find_run,
    output wire logic [31:0] phase_find_amps,
    output wire logic [7:0]  feedback_poles,
    output wire logic [31:0] res_excite_ratio,
    output wire logic [31:0] res_phase_lag
);
    if (DIV_W != 8) begin : g_div_w_chk
        $error("DIV_W must be 8 to hold pole counts");
    end

    logic [31:0] pfind_ctl_r, pfind_cur_r, poles_r, pscale_r, ratio_r, lag_r;
    fps_chk_t    chk_r, chk_nxt;
    logic [DIV_W-1:0] rem_r;

    fps_scale_if act_if ();
    fps_scale_if err_if ();

    // RL2: split native word into angle and turns
    assign mech_angle = pos_actual[31:0];
    assign turn_count = pos_actual[63:32];

    // RL4: identical scaling for both objects
    assign act_if.pos_in = pos_actual;
    assign act_if.scale  = pscale_r[5:0];
    assign err_if.pos_in = pos_follow_err;
    assign err_if.scale  = pscale_r[5:0];
    assign fb_pos_actual = act_if.pos_out;
    assign fb_follow_err = err_if.pos_out;

    fps_scaler u_act (.clock(clock), .rst_b(rst_b), .sif(act_if));
    fps_scaler u_err (.clock(clock), .rst_b(rst_b), .sif(err_if));

    // Write decode with range checks; out-of-range writes are refused
    wire logic wr_pfind  = prm_wr && prm_addr == FPS_ADDR_PFIND_CTL;
    wire logic wr_cur    = prm_wr && prm_addr == FPS_ADDR_PFIND_CUR;
    wire logic wr_poles  = prm_wr && prm_addr == FPS_ADDR_POLES;
    wire logic wr_pscale = prm_wr && prm_addr == FPS_ADDR_PSCALE;
    wire logic wr_ratio  = prm_wr && prm_addr == FPS_ADDR_RES_RATIO;
    wire logic wr_lag    = prm_wr && prm_addr == FPS_ADDR_RES_LAG;
    // RL9: only 0 or 1 accepted
    wire logic ok_pfind  = prm_wdata <= 32'h0000_0001;
    // RL10: bounded by drive peak current
    wire logic ok_cur    = prm_wdata <= drive_peak_current;
    // RL3: scale limited to 32
    wire logic ok_pscale = prm_wdata <= FPS_PSCALE_MAX;
    // RL11: ratio in thousandths, 1 to 50000
    wire logic ok_ratio  = prm_wdata >= FPS_RATIO_MIN && prm_wdata <= FPS_RATIO_MAX;
    // RL12: lag signed, -180 to 180
    wire logic ok_lag    = $signed(prm_wdata) >= $signed(FPS_LAG_MIN)
                        && $signed(prm_wdata) <= $signed(FPS_LAG_MAX);
    wire logic ok_poles  = 32'(poles_value) >= FPS_POLES_MIN
                        && 32'(poles_value) <= FPS_POLES_MAX;
    wire logic addr_hit  = wr_pfind | wr_cur | wr_poles | wr_pscale | wr_ratio | wr_lag;
    wire logic wr_bad    = (prm_wr && !addr_hit) || wr_poles
                        || (wr_pfind && !ok_pfind) || (wr_cur && !ok_cur)
                        || (wr_pscale && !ok_pscale) || (wr_ratio && !ok_ratio)
                        || (wr_lag && !ok_lag);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pfind_ctl_r <= FPS_RST_PFIND_CTL;
            pfind_cur_r <= FPS_RST_PFIND_CUR;
            pscale_r    <= FPS_RST_PSCALE;
            ratio_r     <= FPS_RST_RES_RATIO;
            lag_r       <= FPS_RST_RES_LAG;
        end else begin
            if (wr_pfind && ok_pfind) pfind_ctl_r <= prm_wdata;
            if (wr_cur && ok_cur) pfind_cur_r <= prm_wdata;
            if (wr_pscale && ok_pscale) pscale_r <= prm_wdata;
            if (wr_ratio && ok_ratio) ratio_r <= prm_wdata;
            if (wr_lag && ok_lag) lag_r <= prm_wdata;
        end
    end

    // RL6: host cannot write; feedback identification loads it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            poles_r <= FPS_RST_POLES;
        end else if (poles_load && ok_poles) begin
            poles_r <= 32'(poles_value);
        end
    end

    // RL7: individual poles feed commutation and velocity scaling
    assign feedback_poles   = poles_r[7:0];
    assign phase_find_run   = pfind_ctl_r[0];
    assign phase_find_amps  = pfind_cur_r;
    assign res_excite_ratio = ratio_r;
    assign res_phase_lag    = lag_r;

    wire logic [31:0] rd_mux =
        prm_addr == FPS_ADDR_PFIND_CTL ? pfind_ctl_r :
        prm_addr == FPS_ADDR_PFIND_CUR ? pfind_cur_r :
        prm_addr == FPS_ADDR_POLES     ? poles_r     :
        prm_addr == FPS_ADDR_PSCALE    ? pscale_r    :
        prm_addr == FPS_ADDR_RES_RATIO ? ratio_r     :
        prm_addr == FPS_ADDR_RES_LAG   ? lag_r       : 32'h0000_0000;
    wire logic rd_hit = prm_addr == FPS_ADDR_PFIND_CTL || prm_addr == FPS_ADDR_PFIND_CUR
                     || prm_addr == FPS_ADDR_POLES || prm_addr == FPS_ADDR_PSCALE
                     || prm_addr == FPS_ADDR_RES_RATIO || prm_addr == FPS_ADDR_RES_LAG;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prm_rdata <= 32'h0000_0000;
            prm_err   <= 1'b0;
        end else begin
            prm_rdata <= prm_rd ? rd_mux : prm_rdata;
            prm_err   <= wr_bad || (prm_rd && !rd_hit);
        end
    end

    // Pole ratio check by repeated subtraction, one step a cycle
    always_comb begin
        chk_nxt = chk_r;
        unique case (chk_r)
            FPS_CHK_IDLE: if (enable_req) chk_nxt = FPS_CHK_RUN;
            FPS_CHK_RUN:  if (rem_r < poles_r[7:0]) chk_nxt = FPS_CHK_DONE;
            FPS_CHK_DONE: chk_nxt = FPS_CHK_IDLE;
        endcase
    end

    // RL8: fault when remainder is not zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            chk_r      <= FPS_CHK_IDLE;
            rem_r      <= '0;
            enable_ok  <= 1'b0;
            pole_fault <= 1'b0;
        end else begin
            chk_r <= chk_nxt;
            if (chk_r == FPS_CHK_IDLE && enable_req) begin
                rem_r      <= motor_poles;
                enable_ok  <= 1'b0;
                pole_fault <= 1'b0;
            end else if (chk_r == FPS_CHK_RUN && rem_r >= poles_r[7:0]) begin
                rem_r <= rem_r - poles_r[7:0];
            end else if (chk_r == FPS_CHK_RUN) begin
                enable_ok  <= rem_r == '0;
                pole_fault <= rem_r != '0;
            end
        end
    end

    a_ratio_fault: assert property (@(posedge clock) disable iff (!rst_b) // RL8
        (chk_r == FPS_CHK_RUN && rem_r < poles_r[7:0]) |=> pole_fault == ($past(rem_r) != '0))
        else $error("pole fault does not match remainder");
    a_ratio_ok: assert property (@(posedge clock) disable iff (!rst_b) // RL8
        (chk_r == FPS_CHK_RUN && rem_r < poles_r[7:0]) |=> enable_ok == ($past(rem_r) == '0))
        else $error("enable result does not match remainder");
    a_check_clear: assert property (@(posedge clock) disable iff (!rst_b) // RL8
        (chk_r == FPS_CHK_IDLE && enable_req) |=> !enable_ok && !pole_fault)
        else $error("old check result not cleared on enable");
    a_ok_excl: assert property (@(posedge clock) disable iff (!rst_b) // RL8
        !(enable_ok && pole_fault))
        else $error("enable and fault together");
    a_scale_range: assert property (@(posedge clock) disable iff (!rst_b) // RL3
        pscale_r <= FPS_PSCALE_MAX)
        else $error("scale out of range");
    a_poles_range: assert property (@(posedge clock) disable iff (!rst_b) // RL6
        poles_r >= FPS_POLES_MIN && poles_r <= FPS_POLES_MAX)
        else $error("pole count out of range");
    a_poles_ro: assert property (@(posedge clock) disable iff (!rst_b) // RL6
        (wr_poles && !poles_load) |=> $stable(poles_r))
        else $error("host write changed pole count");
    a_pfind_bin: assert property (@(posedge clock) disable iff (!rst_b) // RL9
        pfind_ctl_r <= 32'h0000_0001)
        else $error("phase-find control not 0 or 1");
    a_cur_limit: assert property (@(posedge clock) disable iff (!rst_b) // RL10
        (wr_cur && !ok_cur) |=> $stable(pfind_cur_r))
        else $error("current above peak accepted");
    a_same_scale: assert property (@(posedge clock) disable iff (!rst_b) // RL4
        (pos_actual == pos_follow_err) |=> fb_pos_actual == fb_follow_err)
        else $error("objects scaled differently");
    a_lag_range: assert property (@(posedge clock) disable iff (!rst_b) // RL12
        $signed(lag_r) >= -32'sd180 && $signed(lag_r) <= 32'sd180)
        else $error("phase lag out of range");
    a_ratio_range: assert property (@(posedge clock) disable iff (!rst_b) // RL11
        ratio_r >= FPS_RATIO_MIN && ratio_r <= FPS_RATIO_MAX)
        else $error("ratio out of range");
    a_pfind_keep: assert property (@(posedge clock) disable iff (!rst_b) // RL9
        (wr_pfind && !ok_pfind) |=> $stable(pfind_ctl_r))
        else $error("illegal phase-find value accepted");
    a_scale_keep: assert property (@(posedge clock) disable iff (!rst_b) // RL3
        (wr_pscale && !ok_pscale) |=> $stable(pscale_r))
        else $error("illegal scale accepted");
    a_ratio_keep: assert property (@(posedge clock) disable iff (!rst_b) // RL11
        (wr_ratio && !ok_ratio) |=> $stable(ratio_r))
        else $error("illegal ratio accepted");
    a_lag_keep: assert property (@(posedge clock) disable iff (!rst_b) // RL12
        (wr_lag && !ok_lag) |=> $stable(lag_r))
        else $error("illegal phase lag accepted");
    a_poles_err: assert property (@(posedge clock) disable iff (!rst_b) // RL6
        wr_poles |=> prm_err)
        else $error("pole count write not flagged");
endmodule : fps_top

// ---- testbench/fps_master_model.sv ----
/*
 * Fieldbus master model: takes the two scaled position objects every cycle.
 * Assumes the block's outputs live on the same clock as this model.
 */
`timescale 1ns/100ps
module fps_master_model (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [31:0] fb_pos_actual,
    input  wire logic [31:0] fb_follow_err,
    output logic      [31:0] got_pos,
    output logic      [31:0] got_ferr
);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            got_pos  <= 32'h0;
            got_ferr <= 32'h0;
        end else begin
            got_pos  <= fb_pos_actual;
            got_ferr <= fb_follow_err;
        end
    end
endmodule : fps_master_model

// ---- testbench/tb_top.sv ----
/*
 * Self-checking bench for fps_top over its parameter port.
 * Assumes one-cycle parameter strobes and a registered answer on the taking edge.
 */
`timescale 1ns/100ps
module tb_top
    import fps_pkg::*;
;
    logic clock = 1'b0, rst_b = 1'b0, prm_wr = 1'b0, prm_rd = 1'b0;
    logic poles_load = 1'b0, enable_req = 1'b0, e, enable_ok, pole_fault, phase_find_run;
    logic [15:0] prm_addr = 16'h0;
    logic [31:0] prm_wdata = 32'h0, prm_rdata, d, fb_pos_actual, fb_follow_err, mech_angle;
    logic [31:0] turn_count, phase_find_amps, res_excite_ratio, res_phase_lag;
    logic [31:0] got_pos, got_ferr, drive_peak_current = 32'h0000_0064;
    logic [63:0] pos_actual = 64'h0, pos_follow_err = 64'h0;
    logic [7:0]  poles_value = 8'h0, motor_poles = 8'h08, feedback_poles;
    int          err_total = 0, total_checks = 0, n = 0;
    fps_top #(.DIV_W(8)) fps_top_inst (.clock(clock), .rst_b(rst_b), .prm_wr(prm_wr),
        .prm_rd(prm_rd), .prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata),
        .prm_err(e), .pos_actual(pos_actual), .pos_follow_err(pos_follow_err),
        .fb_pos_actual(fb_pos_actual), .fb_follow_err(fb_follow_err),
        .mech_angle(mech_angle), .turn_count(turn_count), .poles_load(poles_load),
        .poles_value(poles_value), .motor_poles(motor_poles),
        .drive_peak_current(drive_peak_current), .enable_req(enable_req),
        .enable_ok(enable_ok), .pole_fault(pole_fault), .phase_find_run(phase_find_run),
        .phase_find_amps(phase_find_amps), .feedback_poles(feedback_poles),
        .res_excite_ratio(res_excite_ratio), .res_phase_lag(res_phase_lag));
    fps_master_model fps_master_model_inst (.clock(clock), .rst_b(rst_b),
        .fb_pos_actual(fb_pos_actual), .fb_follow_err(fb_follow_err),
        .got_pos(got_pos), .got_ferr(got_ferr));
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // One strobe cycle; answer lands on the taking edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] v);
        @(posedge clock);
        prm_wr <= w;
        prm_rd <= !w;
        prm_addr <= a;
        prm_wdata <= v;
        @(posedge clock);
        prm_wr <= 1'b0;
        prm_rd <= 1'b0;
        #1 d = prm_rdata;
    endtask : acc
    function automatic logic [31:0] scl(input logic [63:0] p, input int s);
        return 32'(p >> (32 - s));
    endfunction : scl
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        finish_test();
    end
    logic [15:0] ra [6] = '{FPS_ADDR_PFIND_CTL, FPS_ADDR_PFIND_CUR, FPS_ADDR_POLES,
                            FPS_ADDR_PSCALE, FPS_ADDR_RES_RATIO, FPS_ADDR_RES_LAG};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h2, 32'h14, 32'h1F4, 32'hFFFF_FFFE};
    int sc [6] = '{20, 16, 0, 1, 31, 32};
    logic [15:0] ba [9] = '{16'h0130, 16'h012E, 16'h012A, 16'h012C, 16'h0136,
                            16'h0132, 16'h0134, 16'h0132, 16'h0134};
    logic [31:0] bv [9] = '{32'h21, 32'h4, 32'h2, 32'h65, 32'h1, 32'h0, 32'hB5,
                            32'hC351, 32'hFFFF_FF4B};
    logic [31:0] gv [4] = '{32'h1, 32'h64, 32'hC350, 32'hFFFF_FF4C};
    logic [7:0]  pl [5] = '{8'h02, 8'h03, 8'h08, 8'h10, 8'h80};
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        foreach (ra[i]) begin
            acc(1'b0, ra[i], 32'h0);
            chk("reset_value", rv[i], d);
        end
        @(posedge clock);
        pos_actual <= 64'h0000_0023_1234_ABCD;
        pos_follow_err <= 64'hFFFF_FFFF_8000_0001;
        foreach (sc[i]) begin
            acc(1'b1, FPS_ADDR_PSCALE, 32'(sc[i]));
            chk("scale_err", 32'h0, {31'h0, e});
            repeat (3) @(posedge clock);
            #1 chk("fb_pos", scl(pos_actual, sc[i]), fb_pos_actual);
            chk("fb_ferr", scl(pos_follow_err, sc[i]), fb_follow_err);
            chk("master_pos", scl(pos_actual, sc[i]), got_pos);
            chk("master_ferr", scl(pos_follow_err, sc[i]), got_ferr);
        end
        chk("angle", 32'h1234_ABCD, mech_angle);
        chk("turns", 32'h0000_0023, turn_count);
        foreach (ba[i]) begin
            acc(1'b1, ba[i], bv[i]);
            chk("refused", 32'h1, {31'h0, e});
        end
        acc(1'b0, FPS_ADDR_PSCALE, 32'h0);
        chk("scale_kept", 32'h20, d);
        acc(1'b0, FPS_ADDR_POLES, 32'h0);
        chk("poles_kept", 32'h2, d);
        foreach (gv[i]) begin
            acc(1'b1, ra[i < 2 ? i : i + 2], gv[i]);
            chk("legal_err", 32'h0, {31'h0, e});
            acc(1'b0, ra[i < 2 ? i : i + 2], 32'h0);
            chk("legal_rw", gv[i], d);
        end
        chk("pfind_run", 32'h1, {31'h0, phase_find_run});
        chk("pfind_amps", 32'h64, phase_find_amps);
        chk("ratio", 32'hC350, res_excite_ratio);
        chk("lag", 32'hFFFF_FF4C, res_phase_lag);
        foreach (pl[i]) begin
            @(posedge clock);
            poles_load <= 1'b1;
            poles_value <= (i == 4) ? 8'hC8 : pl[i];
            @(posedge clock);
            poles_load <= 1'b0;
            enable_req <= 1'b1;
            @(posedge clock);
            enable_req <= 1'b0;
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while (n < 300 && enable_ok !== 1'b1 && pole_fault !== 1'b1);
            chk("poles", {24'h0, (i == 4) ? 8'h10 : pl[i]}, {24'h0, feedback_poles});
            chk("ratio_cycles", 32'(motor_poles / ((i == 4) ? 8'h10 : pl[i])) + 32'h1, n);
            chk("ratio_ok", {31'h0, i == 0 || i == 2}, {31'h0, enable_ok});
            chk("ratio_fault", {31'h0, !(i == 0 || i == 2)}, {31'h0, pole_fault});
        end
        finish_test();
    end
endmodule : tb_top
